//--- timer_pkg.sv
`default_nettype none
package timer_pkg;
   localparam int unsigned ADDR_W = 4;
   localparam int unsigned DATA_W = 16;
   localparam int unsigned CNT_W = 16;

   localparam logic [ADDR_W-1:0] OFF_CTRL = 4'h0;
   localparam logic [ADDR_W-1:0] OFF_TOGGLE = 4'h1;
   localparam logic [ADDR_W-1:0] OFF_CMP_A = 4'h2;
   localparam logic [ADDR_W-1:0] OFF_CMP_B = 4'h3;
   localparam logic [ADDR_W-1:0] OFF_CAP_A = 4'h4;
   localparam logic [ADDR_W-1:0] OFF_CAP_B = 4'h5;
   localparam logic [ADDR_W-1:0] OFF_COUNT = 4'h6;
   localparam logic [ADDR_W-1:0] OFF_SW_CAP = 4'h7;

   // toggle_control field positions
   localparam int unsigned TOG_EN_LSB = 0;
   localparam int unsigned TOG_FORCE_LSB = 4;
   localparam int unsigned TOG_FF_POS = 6;

   // shared prescaler taps (phi_t1, phi_t4, phi_t16)
   localparam int unsigned PRE_W_DEF = 9;
   localparam int unsigned TAP_T1 = 3;
   localparam int unsigned TAP_T4 = 5;
   localparam int unsigned TAP_T16 = 7;

   localparam int unsigned EDGE_A = 0;
   localparam int unsigned EDGE_B = 1;
   localparam int unsigned EDGE_EXT = 2;
   localparam int unsigned EDGE_N = 3;

   typedef enum logic [1:0] {
      CLK_TRIG_A = 2'h0,
      CLK_T1 = 2'h1,
      CLK_T4 = 2'h2,
      CLK_T16 = 2'h3
   } clk_sel_t;

   typedef enum logic [1:0] {
      CAP_OFF = 2'h0,
      CAP_EDGES = 2'h1,
      CAP_WIDTH = 2'h2,
      CAP_EXT = 2'h3
   } capture_mode_t;

   typedef enum logic [1:0] {
      FORCE_TOGGLE = 2'h0,
      FORCE_SET = 2'h1,
      FORCE_CLEAR = 2'h2,
      FORCE_NONE = 2'h3
   } toggle_force_cmd_t;

   typedef struct packed {
      capture_mode_t capture_mode;
      clk_sel_t clk_sel;
      logic clear_on_compare_b_en;
      logic double_buffer_en;
      logic prescaler_run;
      logic counter_run;
   } ctrl_t;

   typedef struct packed {
      logic toggle_on_capture_b;
      logic toggle_on_capture_a;
      logic toggle_on_compare_b;
      logic toggle_on_compare_a;
   } toggle_control_t;

   typedef struct packed {
      logic t1;
      logic t4;
      logic t16;
   } pre_ticks_t;

   localparam ctrl_t CTRL_RESET = 8'h00;
   localparam toggle_control_t TOG_RESET = 4'h0;
   localparam logic TFF_RESET = 1'b0;
endpackage
`default_nettype wire

//--- edge_sync.sv
`timescale 1ns/1ns
`default_nettype none
module edge_sync
   import timer_pkg::*;
#(
   parameter int unsigned N = EDGE_N
) (
   input wire logic clk_sys,
   input wire logic rst_b,
   input wire logic [N-1:0] pins_in,
   output logic [N-1:0] rise,
   output logic [N-1:0] fall
);
   if (N < 1) begin : g_chk
      $error("edge_sync needs at least one input");
   end

   typedef struct packed {
      logic [N-1:0] s1;
      logic [N-1:0] s2;
      logic [N-1:0] s3;
      logic [N-1:0] level;
      logic [N-1:0] rise;
      logic [N-1:0] fall;
   } sync_st_t;

   sync_st_t st;
   sync_st_t next_st;
   logic [N-1:0] agree;

   always_comb begin
      next_st = st;
      next_st.s1 = pins_in;
      next_st.s2 = st.s1;
      next_st.s3 = st.s2;
      // a change counts only once stages two and three agree
      agree = ~(st.s2 ^ st.s3);
      next_st.level = (st.level & ~agree) | (st.s2 & agree);
      next_st.rise = next_st.level & ~st.level;
      next_st.fall = ~next_st.level & st.level;
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign rise = st.rise;
   assign fall = st.fall;

   a_edge_single: assert property (@(posedge clk_sys) disable iff (!rst_b)
      (rise != '0) |=> ((rise & $past(rise)) == '0))
      else $error("edge pulse lasted more than one cycle");
endmodule
`default_nettype wire

//--- prescaler.sv
`timescale 1ns/1ns
`default_nettype none
module prescaler
   import timer_pkg::*;
#(
   parameter int unsigned PRE_W = PRE_W_DEF
) (
   input wire logic clk_sys,
   input wire logic rst_b,
   input wire logic prescaler_run,
   output pre_ticks_t ticks
);
   if (TAP_T16 >= PRE_W || TAP_T1 < 1) begin : g_chk
      $error("prescaler too narrow for its taps");
   end

   typedef struct packed {
      logic [PRE_W-1:0] cnt;
      pre_ticks_t ticks;
   } pre_st_t;

   pre_st_t st;
   pre_st_t next_st;

   always_comb begin
      next_st = st;
      if (!prescaler_run) begin
         next_st = '0;
      end else begin
         next_st.cnt = st.cnt + PRE_W'(1);
         next_st.ticks.t1 = &st.cnt[TAP_T1-1:0];
         next_st.ticks.t4 = &st.cnt[TAP_T4-1:0];
         next_st.ticks.t16 = &st.cnt[TAP_T16-1:0];
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign ticks = st.ticks;

   a_presc_stopped: assert property (@(posedge clk_sys) disable iff (!rst_b)
      !prescaler_run |=> (st.cnt == '0 && st.ticks == '0))
      else $error("prescaler not cleared while stopped");
   a_presc_counts: assert property (@(posedge clk_sys) disable iff (!rst_b)
      prescaler_run |=> st.cnt == PRE_W'($past(st.cnt) + PRE_W'(1)))
      else $error("prescaler failed to count");
endmodule
`default_nettype wire

//--- timer_pulse_gen_capture.sv
`timescale 1ns/1ns
`default_nettype none
module timer_pulse_gen_capture
   import timer_pkg::*;
(
   input wire logic clk_sys,
   input wire logic rst_b,
   input wire logic [ADDR_W-1:0] reg_addr,
   input wire logic [DATA_W-1:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [DATA_W-1:0] reg_rdata,
   input wire logic trigger_in_a,
   input wire logic trigger_in_b,
   input wire logic ext_timer_toggle,
   output logic pulse_out,
   output logic compare_a_irq,
   output logic compare_b_irq,
   output logic trigger_a_irq,
   output logic trigger_b_irq
);
   typedef struct packed {
      ctrl_t ctrl;
      toggle_control_t tog;
      logic pulse_toggle_ff;
      logic [CNT_W-1:0] up_counter;
      logic [CNT_W-1:0] compare_a;
      logic [CNT_W-1:0] compare_a_buf;
      logic [CNT_W-1:0] compare_b;
      logic [CNT_W-1:0] capture_a;
      logic [CNT_W-1:0] capture_b;
      logic [DATA_W-1:0] rdata;
      logic compare_a_irq;
      logic compare_b_irq;
      logic trigger_a_irq;
      logic trigger_b_irq;
   } timer_st_t;

   timer_st_t st;
   timer_st_t next_st;
   logic [EDGE_N-1:0] rise;
   logic [EDGE_N-1:0] fall;
   pre_ticks_t ticks;
   logic tick;
   logic adv;
   logic hit_a;
   logic hit_b;
   logic cap_a_ev;
   logic cap_b_ev;
   logic sw_cap;
   logic toggle_now;
   logic [CNT_W-1:0] cnt_next;
   toggle_force_cmd_t force_cmd;

   // pins reach the capture logic four edges after they move;
   // pulses shorter than two cycles may be lost
   edge_sync #(.N(EDGE_N)) u_sync (
      .clk_sys(clk_sys),
      .rst_b(rst_b),
      .pins_in({ext_timer_toggle, trigger_in_b, trigger_in_a}),
      .rise(rise),
      .fall(fall)
   );

   prescaler #(.PRE_W(PRE_W_DEF)) u_pre (
      .clk_sys(clk_sys),
      .rst_b(rst_b),
      .prescaler_run(st.ctrl.prescaler_run),
      .ticks(ticks)
   );

   function automatic logic [DATA_W-1:0] read_mux(input timer_st_t s,
                                                  input logic [ADDR_W-1:0] a);
      logic [DATA_W-1:0] d;
      d = '0;
      unique case (a)
         OFF_CTRL: d = DATA_W'(s.ctrl);
         OFF_TOGGLE: begin
            d[TOG_EN_LSB +: 4] = s.tog;
            d[TOG_FF_POS] = s.pulse_toggle_ff;
         end
         OFF_CMP_A: d = s.compare_a;
         OFF_CMP_B: d = s.compare_b;
         OFF_CAP_A: d = s.capture_a;
         OFF_CAP_B: d = s.capture_b;
         OFF_COUNT: d = s.up_counter;
         default: d = '0;
      endcase
      return d;
   endfunction

   assign sw_cap = reg_wr && (reg_addr == OFF_SW_CAP);
   assign force_cmd = toggle_force_cmd_t'(reg_wdata[TOG_FORCE_LSB +: 2]);

   always_comb begin
      next_st = st;
      unique case (st.ctrl.clk_sel)
         CLK_TRIG_A: tick = rise[EDGE_A];
         CLK_T1: tick = ticks.t1;
         CLK_T4: tick = ticks.t4;
         CLK_T16: tick = ticks.t16;
      endcase
      adv = st.ctrl.counter_run && tick;
      // stopping the counter also clears it
      if (!st.ctrl.counter_run) begin
         cnt_next = '0;
      end else if (adv) begin
         if (st.ctrl.clear_on_compare_b_en && st.up_counter == st.compare_b) begin
            cnt_next = '0;
         end else begin
            cnt_next = st.up_counter + CNT_W'(1);
         end
      end else begin
         cnt_next = st.up_counter;
      end
      next_st.up_counter = cnt_next;
      // a match counts once, on the tick that reaches the value
      hit_a = adv && cnt_next == st.compare_a;
      hit_b = adv && cnt_next == st.compare_b;
      next_st.compare_a_irq = hit_a;
      next_st.compare_b_irq = hit_b;

      cap_a_ev = sw_cap
         || ((st.ctrl.capture_mode == CAP_EDGES || st.ctrl.capture_mode == CAP_WIDTH)
             && rise[EDGE_A])
         || (st.ctrl.capture_mode == CAP_EXT && rise[EDGE_EXT]);
      cap_b_ev = (st.ctrl.capture_mode == CAP_EDGES && rise[EDGE_B])
         || (st.ctrl.capture_mode == CAP_WIDTH && fall[EDGE_A])
         || (st.ctrl.capture_mode == CAP_EXT && fall[EDGE_EXT]);
      if (cap_a_ev) begin
         next_st.capture_a = st.up_counter;
      end
      if (cap_b_ev) begin
         next_st.capture_b = st.up_counter;
      end
      if (st.ctrl.capture_mode == CAP_WIDTH) begin
         next_st.trigger_a_irq = fall[EDGE_A];
      end else begin
         next_st.trigger_a_irq = rise[EDGE_A];
      end
      next_st.trigger_b_irq = rise[EDGE_B];

      // simultaneous sources cancel in pairs
      toggle_now = (hit_a && st.tog.toggle_on_compare_a)
         ^ (hit_b && st.tog.toggle_on_compare_b)
         ^ (cap_a_ev && st.tog.toggle_on_capture_a)
         ^ (cap_b_ev && st.tog.toggle_on_capture_b);
      next_st.pulse_toggle_ff = st.pulse_toggle_ff ^ toggle_now;

      if (hit_b && st.ctrl.double_buffer_en) begin
         next_st.compare_a = st.compare_a_buf;
      end

      if (reg_wr) begin
         unique case (reg_addr)
            OFF_CTRL: next_st.ctrl = ctrl_t'(reg_wdata[7:0]);
            OFF_TOGGLE: begin
               next_st.tog = toggle_control_t'(reg_wdata[TOG_EN_LSB +: 4]);
               // a software force wins over a same-cycle hardware toggle
               unique case (force_cmd)
                  FORCE_TOGGLE: next_st.pulse_toggle_ff = ~st.pulse_toggle_ff;
                  FORCE_SET: next_st.pulse_toggle_ff = 1'b1;
                  FORCE_CLEAR: next_st.pulse_toggle_ff = 1'b0;
                  FORCE_NONE: begin
                  end
               endcase
            end
            OFF_CMP_A: begin
               next_st.compare_a_buf = reg_wdata;
               if (!st.ctrl.double_buffer_en) begin
                  next_st.compare_a = reg_wdata;
               end
            end
            OFF_CMP_B: next_st.compare_b = reg_wdata;
            default: begin
            end
         endcase
      end
      if (reg_rd) begin
         next_st.rdata = read_mux(st, reg_addr);
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         st <= '0;
         st.ctrl <= CTRL_RESET;
         st.tog <= TOG_RESET;
         st.pulse_toggle_ff <= TFF_RESET;
      end else begin
         st <= next_st;
      end
   end

   assign reg_rdata = st.rdata;
   assign pulse_out = st.pulse_toggle_ff;
   assign compare_a_irq = st.compare_a_irq;
   assign compare_b_irq = st.compare_b_irq;
   assign trigger_a_irq = st.trigger_a_irq;
   assign trigger_b_irq = st.trigger_b_irq;

   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!rst_b);

   a_cmp_a_match: assert property (compare_a_irq && !compare_b_irq |-> st.up_counter == st.compare_a)
      else $error("compare_a_irq without a match");
   a_cmp_b_match: assert property (compare_b_irq |-> st.up_counter == st.compare_b)
      else $error("compare_b_irq without a match");
   a_clear_on_b: assert property (adv && st.ctrl.clear_on_compare_b_en
      && st.up_counter == st.compare_b |=> st.up_counter == '0)
      else $error("counter not cleared at compare_b");
   a_dbuf_load: assert property (hit_b && st.ctrl.double_buffer_en && !reg_wr
      |=> st.compare_a == $past(st.compare_a_buf))
      else $error("buffer not moved into compare_a");
   a_dbuf_write: assert property (reg_wr && reg_addr == OFF_CMP_A && st.ctrl.double_buffer_en
      && !hit_b |=> st.compare_a == $past(st.compare_a) && st.compare_a_buf == $past(reg_wdata))
      else $error("buffered write reached compare_a");
   a_cap_a_edge: assert property (st.ctrl.capture_mode == CAP_EDGES && rise[EDGE_A]
      |=> st.capture_a == $past(st.up_counter) && trigger_a_irq)
      else $error("capture_a missed trigger_a rise");
   a_cap_b_fall: assert property (st.ctrl.capture_mode == CAP_WIDTH && fall[EDGE_A]
      |=> st.capture_b == $past(st.up_counter) && trigger_a_irq)
      else $error("capture_b missed trigger_a fall");
   a_cap_ext_rise: assert property (st.ctrl.capture_mode == CAP_EXT && rise[EDGE_EXT] && !sw_cap
      |=> st.capture_a == $past(st.up_counter))
      else $error("capture_a missed ext toggle rise");
   a_cap_a_hold: assert property (!cap_a_ev |=> $stable(st.capture_a))
      else $error("capture_a changed without event");
   a_force_set: assert property (reg_wr && reg_addr == OFF_TOGGLE && force_cmd == FORCE_SET
      |=> pulse_out)
      else $error("force set ignored");
   a_ext_count: assert property (st.ctrl.clk_sel == CLK_TRIG_A && st.ctrl.counter_run
      && rise[EDGE_A] && !st.ctrl.clear_on_compare_b_en && !(reg_wr && reg_addr == OFF_CTRL)
      |=> st.up_counter == CNT_W'($past(st.up_counter) + CNT_W'(1)))
      else $error("external edge not counted");
   a_toggle_flip: assert property (toggle_now && !(reg_wr && reg_addr == OFF_TOGGLE)
      |=> pulse_out != $past(pulse_out))
      else $error("pulse flip-flop did not toggle");
   a_force_clear: assert property (reg_wr && reg_addr == OFF_TOGGLE && force_cmd == FORCE_CLEAR
      |=> !pulse_out)
      else $error("force clear ignored");
   a_dbuf_off_write: assert property (reg_wr && reg_addr == OFF_CMP_A && !st.ctrl.double_buffer_en
      |=> st.compare_a == $past(reg_wdata))
      else $error("unbuffered write missed compare_a");
   a_free_run: assert property (adv && st.ctrl.clk_sel != CLK_TRIG_A
      && !st.ctrl.clear_on_compare_b_en
      |=> st.up_counter == CNT_W'($past(st.up_counter) + CNT_W'(1)))
      else $error("prescaler tick not counted");
   // match pulses can never repeat on adjacent cycles: ticks are single-cycle
   a_irq_a_single: assert property (compare_a_irq |=> !compare_a_irq)
      else $error("compare_a_irq longer than one cycle");
   a_irq_b_single: assert property (compare_b_irq |=> !compare_b_irq)
      else $error("compare_b_irq longer than one cycle");

   // capture side
   a_cap_b_edge: assert property (st.ctrl.capture_mode == CAP_EDGES && rise[EDGE_B]
      |=> st.capture_b == $past(st.up_counter))
      else $error("capture_b missed trigger_b rise");
   a_trig_b_rise: assert property (rise[EDGE_B] |=> trigger_b_irq)
      else $error("trigger_b_irq missing");
   a_cap_ext_fall: assert property (st.ctrl.capture_mode == CAP_EXT && fall[EDGE_EXT]
      |=> st.capture_b == $past(st.up_counter))
      else $error("capture_b missed ext toggle fall");
   a_cap_b_hold: assert property (!cap_b_ev |=> $stable(st.capture_b))
      else $error("capture_b changed without event");
   a_trig_a_rise: assert property (st.ctrl.capture_mode != CAP_WIDTH && rise[EDGE_A]
      |=> trigger_a_irq)
      else $error("trigger_a_irq missed rise");
   a_trig_a_single: assert property (trigger_a_irq |=> !trigger_a_irq)
      else $error("trigger_a_irq longer than one cycle");
   a_cap_toggle: assert property (cap_a_ev && st.tog.toggle_on_capture_a && !hit_a && !hit_b
      && !cap_b_ev && !(reg_wr && reg_addr == OFF_TOGGLE)
      |=> pulse_out != $past(pulse_out))
      else $error("capture did not toggle flip-flop");

   c_dbuf_period: cover property (compare_b_irq && st.ctrl.double_buffer_en);
   c_width_irq: cover property (trigger_a_irq && st.ctrl.capture_mode == CAP_WIDTH);
   c_pulse_rise: cover property ($rose(pulse_out) ##[1:200] $fell(pulse_out));
   c_sw_capture: cover property (sw_cap && st.tog.toggle_on_capture_a);
endmodule
`default_nettype wire

//--- trig_source.sv
`timescale 1ns/1ns
`default_nettype none
module trig_source (
   input wire logic clk_sys,
   input wire logic [2:0] fire,
   input wire logic [3:0] width,
   output logic [2:0] pins,
   output logic busy
);
   // pins rest low; high for width+1 cycles, then low width cycles before the next pulse,
   // so no two edges come closer than the synchroniser can follow
   logic [4:0] left;
   initial begin
      pins = 3'h0;
      left = 5'h00;
   end
   always @(posedge clk_sys) begin
      if (left != 5'h00) begin
         left <= left - 5'h01;
         if (left == {1'b0, width})
            pins <= 3'h0;
      end else if (fire != 3'h0) begin
         pins <= fire;
         left <= {width, 1'b0};
      end
   end
   assign busy = (left != 5'h00);
endmodule
`default_nettype wire

//--- testbench.sv
`timescale 1ns/1ns
`default_nettype none
module testbench;
   import timer_pkg::*;
   logic clk_sys = 1'b0;
   logic rst_b = 1'b0;
   logic [ADDR_W-1:0] reg_addr = 4'h0;
   logic [DATA_W-1:0] reg_wdata = 16'h0000;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [DATA_W-1:0] reg_rdata;
   logic [2:0] fire = 3'h0;
   logic [2:0] pins;
   logic busy, pulse_out, compare_a_irq, compare_b_irq, trigger_a_irq, trigger_b_irq;
   int fail_count = 0;
   int compares = 0;
   int cyc = 0, n_a = 0, n_b = 0, n_ta = 0, n_tb = 0, edges = 0;
   int t_a = 0, t_b = 0, t_bp = 0, t_ta = 0, t_f = 0, k, a, b, i;
   logic prev_po = 1'b0;
   logic ffv;
   logic [31:0] seed = 32'h0e14;
   logic [1:0] cmds [4] = '{2'h1, 2'h2, 2'h0, 2'h3};

   always #10 clk_sys = ~clk_sys;

   trig_source src (.clk_sys(clk_sys), .fire(fire), .width(4'ha), .pins(pins), .busy(busy));

   timer_pulse_gen_capture dut (
      .clk_sys(clk_sys), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .trigger_in_a(pins[0]), .trigger_in_b(pins[1]), .ext_timer_toggle(pins[2]),
      .pulse_out(pulse_out), .compare_a_irq(compare_a_irq), .compare_b_irq(compare_b_irq),
      .trigger_a_irq(trigger_a_irq), .trigger_b_irq(trigger_b_irq));

   always @(posedge clk_sys) begin
      cyc = cyc + 1;
      if (compare_a_irq === 1'b1) begin
         n_a = n_a + 1;
         t_a = cyc;
      end
      if (compare_b_irq === 1'b1) begin
         n_b = n_b + 1;
         t_bp = t_b;
         t_b = cyc;
      end
      if (trigger_a_irq === 1'b1) begin
         n_ta = n_ta + 1;
         t_ta = cyc;
      end
      if (trigger_b_irq === 1'b1)
         n_tb = n_tb + 1;
      if (pulse_out !== prev_po)
         edges = edges + 1;
      prev_po = pulse_out;
   end

   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] x;
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction

   function automatic logic next_ff(input logic [1:0] cmd, input logic old);
      case (cmd)
         2'h0: return ~old;
         2'h1: return 1'b1;
         2'h2: return 1'b0;
         default: return old;
      endcase
   endfunction

   task automatic final_report();
      if (fail_count == 0 && compares > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      compares++;
      if (seen !== exp) begin
         fail_count++;
         $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic wr(input logic [3:0] ad, input logic [15:0] d);
      @(posedge clk_sys);
      reg_wr <= 1'b1;
      reg_addr <= ad;
      reg_wdata <= d;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
   endtask

   // read data appear in the cycle after the strobe and hold until the next read
   task automatic rd_chk(input logic [3:0] ad, input logic [15:0] exp);
      @(posedge clk_sys);
      reg_rd <= 1'b1;
      reg_addr <= ad;
      @(posedge clk_sys);
      reg_rd <= 1'b0;
      #1;
      check(reg_rdata, exp);
   endtask

   task automatic pulse(input logic [2:0] p);
      @(posedge clk_sys);
      fire <= p;
      #1;
      t_f = cyc;
      @(posedge clk_sys);
      fire <= 3'h0;
      for (int w = 0; w < 40 && (w < 2 || busy); w++)
         @(posedge clk_sys);
      check({15'h0000, busy}, 16'h0000);
      repeat (8) @(posedge clk_sys);
   endtask

   // counts j edges of trigger_in_a, then parks on a stopped prescaler tap
   task automatic count_up(input int j, input logic [15:0] hold);
      wr(OFF_CTRL, 16'h0001);
      repeat (j) pulse(3'h1);
      k = k + j;
      wr(OFF_CTRL, hold);
   endtask

   task automatic wait_b(input int n);
      for (int w = 0; w < 2000 && n_b < n; w++)
         @(posedge clk_sys);
      if (n_b < n) begin
         fail_count++;
         $display("CHECK FAILED at %0t: compare_b match never came", $time);
         final_report();
      end
   endtask

   initial begin
      repeat (8) @(posedge clk_sys);
      rst_b <= 1'b1;
      for (int r = 0; r < 9; r++)
         rd_chk(4'(r), 16'h0000);
      ffv = 1'b0;
      for (int c = 0; c < 4; c++) begin
         wr(OFF_TOGGLE, {10'h000, cmds[c], 4'h0});
         ffv = next_ff(cmds[c], ffv);
         rd_chk(OFF_TOGGLE, {9'h000, ffv, 6'h00});
         check({15'h0000, pulse_out}, {15'h0000, ffv});
      end
      wr(OFF_TOGGLE, 16'h0034);
      wr(OFF_SW_CAP, 16'h0000);
      rd_chk(OFF_TOGGLE, {9'h000, ~ffv, 6'h04});
      k = 0;
      n_ta = 0;
      seed = xs(seed);
      count_up(1 + int'(seed % 6), 16'h0011);
      rd_chk(OFF_COUNT, k[15:0]);
      check(n_ta[15:0], k[15:0]);
      wr(OFF_SW_CAP, 16'h0000);
      rd_chk(OFF_CAP_A, k[15:0]);
      wr(OFF_CTRL, 16'h0051);
      n_tb = 0;
      pulse(3'h2);
      rd_chk(OFF_CAP_B, k[15:0]);
      check(n_tb[15:0], 16'h0001);
      count_up(3, 16'h0051);
      pulse(3'h1);
      rd_chk(OFF_CAP_A, k[15:0]);
      rd_chk(OFF_CAP_B, k[15:0] - 16'h0003);
      count_up(2, 16'h0091);
      n_ta = 0;
      pulse(3'h1);
      rd_chk(OFF_CAP_A, k[15:0]);
      rd_chk(OFF_CAP_B, k[15:0]);
      check(n_ta[15:0], 16'h0001);
      check({15'h0000, (t_ta - t_f) > 11}, 16'h0001);
      count_up(4, 16'h00d1);
      pulse(3'h4);
      rd_chk(OFF_CAP_A, k[15:0]);
      rd_chk(OFF_CAP_B, k[15:0]);
      seed = xs(seed);
      a = 1 + int'(seed % 4);
      b = a + 2 + int'((seed >> 8) % 4);
      wr(OFF_CTRL, 16'h0000);
      wr(OFF_CMP_A, 16'(a));
      wr(OFF_CMP_B, 16'(b));
      wr(OFF_CTRL, 16'h0004);
      wr(OFF_TOGGLE, 16'h0023);
      wr(OFF_CTRL, 16'h001f);
      n_b = 0;
      wait_b(1);
      repeat (4) @(posedge clk_sys);
      #1;
      n_a = 0;
      n_b = 0;
      edges = 0;
      wait_b(3);
      repeat (4) @(posedge clk_sys);
      #1;
      check(n_a[15:0], 16'h0003);
      check(edges[15:0], 16'h0006);
      check(16'(t_b - t_bp), 16'((b + 1) * 8));
      check(16'(t_b - t_a), 16'((b - a) * 8));
      wr(OFF_CMP_A, 16'(a + 1));
      rd_chk(OFF_CMP_A, 16'(a));
      wait_b(4);
      repeat (2) @(posedge clk_sys);
      rd_chk(OFF_CMP_A, 16'(a + 1));
      i = n_a;
      for (int w = 0; w < 200 && n_a == i; w++)
         @(posedge clk_sys);
      check(16'(n_a - i), 16'h0001);
      check(16'(t_a - t_b), 16'((a + 2) * 8));
      final_report();
   end
endmodule
`default_nettype wire
